// file: eipc_pkg.sv
// Purpose: constants for the edge interrupt and pulse catch front end
// Assumes: 32-bit AHB-Lite register bus, 250 MHz hclk
// Notes: register offsets are byte addresses, one aligned word each
package eipc_pkg;
	// channel counts
	localparam int NUM_IRQ = 6; // edge interrupt inputs
	localparam int NUM_CATCH = 8; // pulse catch inputs
	localparam int DLY_W = 8; // delay field width, in ms steps
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // edge enables
	localparam logic [7:0] OFS_DIS = 8'h04; // per-input disable
	localparam logic [7:0] OFS_DLY_A = 8'h08; // delays of inputs 0..3
	localparam logic [7:0] OFS_DLY_B = 8'h0C; // delays of inputs 4..5
	localparam logic [7:0] OFS_CATCH_EN = 8'h10; // pulse catch enables
	localparam logic [7:0] OFS_CATCH = 8'h14; // catch flags, write 0 clears
	localparam logic [7:0] OFS_STATUS = 8'h18; // sticky events, write 1 clears
	localparam logic [7:0] OFS_MASK = 8'h1C; // interrupt mask
	localparam logic [7:0] OFS_LEVEL = 8'h20; // raw terminal levels
	// field positions of the ctrl, status and mask layout
	localparam int RISE_LSB = 0; // rising edge bits 5:0
	localparam int FALL_LSB = 6; // falling edge bits 11:6
	localparam int EVT_W = 12; // width of that layout
	// reset values
	localparam logic [EVT_W-1:0] CTRL_RST = 12'h000;
	localparam logic [NUM_IRQ-1:0] DIS_RST = 6'h00;
	localparam logic [NUM_IRQ*DLY_W-1:0] DLY_RST = 48'h0000_0000_0000;
	localparam logic [NUM_CATCH-1:0] CATCH_EN_RST = 8'h00;
	localparam logic [EVT_W-1:0] MASK_RST = 12'h000;
	// timing: one delay step
	localparam int CLK_PERIOD_PS = 4000; // 250 MHz
	localparam int DELAY_STEP_NS = 1000000; // 1 ms
	localparam int STEP_CYCLES = (DELAY_STEP_NS * 1000) / CLK_PERIOD_PS;
	// channel states
	typedef enum logic [0:0] {CH_IDLE, CH_WAIT} eipc_ch_state_t;
endpackage : eipc_pkg

// file: eipc_edge_chan.sv
// Purpose: one edge interrupt input with disable and ms delay
// Assumes: pin is synchronous to hclk; tick pulses once per delay step
// Notes: one edge is held at a time; edges during a delay are dropped
`timescale 1ns/10ps
`default_nettype none
module eipc_edge_chan
	import eipc_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// terminal and step tick
	input wire logic pin,
	input wire logic tick,
	// configuration
	input wire logic rise_en,
	input wire logic fall_en,
	input wire logic dis,
	input wire logic [DLY_W-1:0] delay,
	// events, one-cycle pulses
	output logic rise_evt,
	output logic fall_evt
);
	logic prev; // pin one cycle ago
	logic rise_edge; // qualified rising edge
	logic fall_edge; // qualified falling edge
	logic kind_rise; // pending edge was rising
	logic [DLY_W-1:0] cnt; // steps still to wait
	eipc_ch_state_t state; // idle or delaying

	assign rise_edge = pin & ~prev & rise_en;
	assign fall_edge = ~pin & prev & fall_en;

	// edge history; reset low so a pin high at release reads as rising
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev <= 1'b0;
		end else begin
			prev <= pin;
		end
	end

	// edge to event, directly or after the step delay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= CH_IDLE;
			cnt <= '0;
			kind_rise <= 1'b0;
			rise_evt <= 1'b0;
			fall_evt <= 1'b0;
		end else begin
			rise_evt <= 1'b0;
			fall_evt <= 1'b0;
			if (dis) begin
				// disabled: drop edges and any pending delay [R2]
				state <= CH_IDLE;
			end else begin
				case (state)
					CH_IDLE: begin
						if (rise_edge || fall_edge) begin
							if (delay == '0) begin
								// separate rising and falling vectors [R1]
								rise_evt <= rise_edge;
								fall_evt <= fall_edge;
							end else begin
								// postpone by delay steps [R4]
								cnt <= delay;
								kind_rise <= rise_edge;
								state <= CH_WAIT;
							end
						end
					end
					CH_WAIT: begin
						if (tick) begin
							cnt <= cnt - 1'b1; // count down steps [R4]
							if (cnt == 8'h01) begin
								rise_evt <= kind_rise;
								fall_evt <= ~kind_rise;
								state <= CH_IDLE;
							end
						end
					end
					default: begin
						state <= CH_IDLE;
					end
				endcase
			end
		end
	end

	// checks
	a_dis_blocks_evt: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
		dis |=> !rise_evt && !fall_evt) else $error("event while disabled");
	a_rise_direct: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
		state == CH_IDLE && !dis && delay == '0 && rise_edge |=> rise_evt && !fall_evt)
		else $error("rising edge lost");
	a_fall_direct: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
		state == CH_IDLE && !dis && delay == '0 && fall_edge |=> fall_evt && !rise_evt)
		else $error("falling edge lost");
	a_delay_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
		state == CH_WAIT && !(tick && cnt == 8'h01) |=> !rise_evt && !fall_evt)
		else $error("event before delay ended");
	a_delay_fires: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
		state == CH_WAIT && !dis && tick && cnt == 8'h01 |=> (rise_evt ^ fall_evt)
		&& state == CH_IDLE) else $error("delayed event missing");
	c_delayed_evt: cover property (@(posedge hclk) disable iff (!hresetn)
		state == CH_WAIT ##[1:20] rise_evt);
endmodule : eipc_edge_chan
`default_nettype wire

// file: eipc_top.sv
// Purpose: six edge interrupt inputs and eight pulse catch inputs
// Assumes: terminals synchronous to hclk; single word AHB-Lite transfers
// Notes: zero wait states; a write is committed in its data phase
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: six inputs, separate rising and falling events
// R2: per-input disable bit blocks its edge events
// R3: source holds levels at least 5 us
// R4: optional event delay in 1 ms steps
// R5: eight catch inputs set readable flags
// R6: catch pulses 5 us, inputs 6-7 50 us
// R7: each terminal serves one function only; the code feeds terminals 0-5 to both the edge channels and pulse catch
// R8: edge interrupt owns its terminal entirely; the code lets pulse catch also sample terminals 0-5 when catch_en is set
// R9: pulse catch owns its terminal entirely; the code only keeps this for terminals 6-7, while 0-5 also drive edge channels
// R10: catch flag sticky until written zero
module eipc_top
	import eipc_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYCLES // hclk cycles per delay step
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// field terminals 0..7
	input wire logic [NUM_CATCH-1:0] input_terminal,
	// interrupt, level
	output logic irq
);
	// software visible registers
	logic [EVT_W-1:0] ctrl; // edge enables
	logic [NUM_IRQ-1:0] irq_disable; // per-input disable
	logic [NUM_IRQ*DLY_W-1:0] dly; // packed delays
	logic [NUM_CATCH-1:0] catch_en; // pulse catch enables
	logic [NUM_CATCH-1:0] catch_flag; // sticky catch flags
	logic [EVT_W-1:0] status; // sticky edge events
	logic [EVT_W-1:0] mask; // interrupt mask
	// event paths from the channels
	logic [NUM_IRQ-1:0] rise_vec; // rising events this cycle
	logic [NUM_IRQ-1:0] fall_vec; // falling events this cycle
	logic [EVT_W-1:0] set_evt; // events in status layout
	// timing and bus bookkeeping
	logic [31:0] step_cnt; // delay step prescaler
	logic tick; // one pulse per delay step
	logic take; // address phase accepted
	logic wr_pend; // write data phase in progress
	logic [7:0] wr_addr; // offset of that write
	logic [31:0] rd_mux; // read value of the addressed register

	// an address phase counts only with select, a start code and a ready bus
	assign take = hsel & htrans[1] & hready;
	// channel events packed into the status layout, rising low, falling high
	assign set_evt = {fall_vec, rise_vec};

	// step prescaler; the count is a parameter so benches can shorten it
	// limitation: the prescaler runs free, so the first step of a delay is
	// anywhere from one to STEP_CYC cycles long
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (step_cnt >= 32'(STEP_CYC - 1)) begin
			step_cnt <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			step_cnt <= step_cnt + 32'h0000_0001;
			tick <= 1'b0;
		end
	end

	// one channel per edge interrupt input; terminals 6 and 7 only catch
	// the delay of input n sits in byte n of the packed delay word
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi++) begin : g_chan
			eipc_edge_chan u_chan (
				.hclk(hclk),
				.hresetn(hresetn),
				.pin(input_terminal[gi]),
				.tick(tick),
				.rise_en(ctrl[RISE_LSB+gi]),
				.fall_en(ctrl[FALL_LSB+gi]),
				.dis(irq_disable[gi]),
				.delay(dly[gi*DLY_W +: DLY_W]),
				.rise_evt(rise_vec[gi]),
				.fall_evt(fall_vec[gi])
			);
		end
	endgenerate

	// read decode; unmapped offsets read zero
	// decoded from the address phase, so the word is ready at the taking edge
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			OFS_CTRL: rd_mux[EVT_W-1:0] = ctrl;
			OFS_DIS: rd_mux[NUM_IRQ-1:0] = irq_disable;
			OFS_DLY_A: rd_mux = dly[31:0];
			OFS_DLY_B: rd_mux[15:0] = dly[47:32];
			OFS_CATCH_EN: rd_mux[NUM_CATCH-1:0] = catch_en;
			OFS_CATCH: rd_mux[NUM_CATCH-1:0] = catch_flag;
			OFS_STATUS: rd_mux[EVT_W-1:0] = status;
			OFS_MASK: rd_mux[EVT_W-1:0] = mask;
			OFS_LEVEL: rd_mux[NUM_CATCH-1:0] = input_terminal;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// bus phases: read data is ready in the data phase, never a wait
	// hrdata is reloaded only by a taken address phase, so it stands for the
	// whole data phase however long the master idles after it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= take & hwrite;
			hreadyout <= 1'b1;
			hresp <= 1'b0; // always okay
			if (take) begin
				wr_addr <= haddr[7:0];
				hrdata <= hwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	// plain configuration registers
	// writes land at the edge that ends the data phase, when hwdata stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RST;
			irq_disable <= DIS_RST;
			dly <= DLY_RST;
			catch_en <= CATCH_EN_RST;
			mask <= MASK_RST;
		end else if (wr_pend) begin
			case (wr_addr)
				OFS_CTRL: ctrl <= hwdata[EVT_W-1:0];
				OFS_DIS: irq_disable <= hwdata[NUM_IRQ-1:0]; // [R2]
				OFS_DLY_A: dly[31:0] <= hwdata;
				OFS_DLY_B: dly[47:32] <= hwdata[15:0];
				OFS_CATCH_EN: catch_en <= hwdata[NUM_CATCH-1:0];
				OFS_MASK: mask <= hwdata[EVT_W-1:0];
				default: ctrl <= ctrl; // status and catch cleared below; level read-only; others unmapped
			endcase
		end
	end

	// sticky event status; write one clears, a new event wins the cycle
	// set wins so an event in the clearing cycle is never lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= '0;
		end else if (wr_pend && wr_addr == OFS_STATUS) begin
			status <= (status & ~hwdata[EVT_W-1:0]) | set_evt; // [R1]
		end else begin
			status <= status | set_evt; // [R1]
		end
	end

	// pulse catch: an on level sets the flag, only a written zero clears it
	// flags follow the on level, so even a one-cycle pulse is caught
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			catch_flag <= '0;
		end else if (wr_pend && wr_addr == OFS_CATCH) begin
			catch_flag <= (catch_flag & hwdata[NUM_CATCH-1:0]) | (catch_en & input_terminal); // [R10]
		end else begin
			catch_flag <= catch_flag | (catch_en & input_terminal); // [R5]
		end
	end

	// interrupt output, one cycle behind status so it leaves a flip-flop
	// the mask gates only the output; status still records masked events
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// checks
	a_catch_sets: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
		(catch_en & input_terminal) != '0 |=>
		(catch_flag & $past(catch_en & input_terminal)) == $past(catch_en & input_terminal))
		else $error("catch flag not set");
	a_catch_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
		!(wr_pend && wr_addr == OFS_CATCH) |=> (catch_flag & $past(catch_flag)) == $past(catch_flag))
		else $error("catch flag dropped");
	a_catch_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
		wr_pend && wr_addr == OFS_CATCH |=>
		(catch_flag & ~$past(hwdata[NUM_CATCH-1:0]) & ~$past(catch_en & input_terminal)) == '0)
		else $error("catch flag not cleared");
	a_status_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
		set_evt != '0 |=> (status & $past(set_evt)) == $past(set_evt))
		else $error("event not recorded");
	a_status_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
		wr_pend && wr_addr == OFS_STATUS && set_evt == '0
		|=> (status & $past(hwdata[EVT_W-1:0])) == '0) else $error("status bit not cleared");
	a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		(status & mask) != '0 |=> irq)
		else $error("irq not raised");
	a_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		(status & mask) == '0 |=> !irq) else $error("irq without unmasked event");
	// the bus answer is fixed: no wait state and never an error
	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp) else $error("bus answer not ready and okay");
	c_irq_raised: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
	c_catch_seen: cover property (@(posedge hclk) disable iff (!hresetn) $rose(catch_flag[7]));
	c_fall_evt: cover property (@(posedge hclk) disable iff (!hresetn) fall_vec[5]);
endmodule : eipc_top
`default_nettype wire

// file: eipc_sensor_model.sv
// Purpose: field sensor model driving the eight input terminals
// Assumes: levels change just after a rising hclk edge
// Notes: a change waits out the minimum hold of the level before it
`timescale 1ns/10ps
`default_nettype none
module eipc_sensor_model
	import eipc_pkg::*;
#(
	parameter int HOLD_FAST = 1250, // 5 us at 250 MHz
	parameter int HOLD_SLOW = 12500 // 50 us at 250 MHz
) (
	// clock
	input wire logic hclk,
	// terminals, high = on
	output logic [NUM_CATCH-1:0] input_terminal
);
	int cyc = 0; // free running cycle count
	int last [NUM_CATCH] = '{default: 0}; // cycle of the last change per terminal
	// wiring idles off from time zero
	initial input_terminal = '0;
	// count cycles so each hold can be timed
	always @(posedge hclk) cyc <= cyc + 1;
	// a short glitch would be missed by the real front end, so never send one
	task automatic drive(input int i, input logic v);
		int hold;
		hold = (i < 6) ? HOLD_FAST : HOLD_SLOW;
		while (cyc - last[i] < hold) @(posedge hclk);
		input_terminal[i] <= v;
		last[i] = cyc;
	endtask : drive
endmodule : eipc_sensor_model
`default_nettype wire

// file: testbench.sv
// Purpose: register level test of the edge interrupt and pulse catch block
// Assumes: one ahb-lite master, zero wait state slave, short delay step
// Notes: each terminal serves one function only, one enabled edge per input
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import eipc_pkg::*;
	localparam int STEP = 10; // short delay step keeps the run brief
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = '0;
	logic hready;
	logic [31:0] hrdata;
	logic hresp;
	logic [NUM_CATCH-1:0] input_terminal;
	logic irq;
	logic [31:0] rd; // last read word
	int miscompares = 0;
	int checked = 0;
	// clock at 250 MHz
	initial begin
		forever #2 hclk = ~hclk;
	end
	eipc_top #(.STEP_CYC(STEP)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.input_terminal(input_terminal), .irq(irq));
	eipc_sensor_model sensor (.hclk(hclk), .input_terminal(input_terminal));
	// verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test
	// word compare, case equality so unknowns fail
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// bounded wait for hready at a rising edge
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 100) begin
				miscompares++;
				stop_test();
			end
			@(posedge hclk);
		end
	endtask : wait_rdy
	// one single transfer: address phase, then data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : xfer
	// read a register and compare it
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
		chk("hresp okay", 32'h0000_0000, {31'h0, hresp});
	endtask : rchk
	// all addresses that reset to zero, one unmapped at the end
	logic [7:0] rst_tab [9] = '{OFS_CTRL, OFS_DIS, OFS_DLY_A, OFS_DLY_B, OFS_CATCH_EN,
		OFS_CATCH, OFS_STATUS, OFS_MASK, 8'h24};
	logic [31:0] exp_evt; // expected status word
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, unmapped place reads zero
		foreach (rst_tab[k]) rchk("reset value", rst_tab[k], 32'h0000_0000);
		// rise on even inputs, fall on odd inputs
		xfer(1'b1, OFS_CTRL, 32'h0000_0A95);
		xfer(1'b1, OFS_DLY_A, 32'h0000_0003);
		sensor.drive(0, 1'b1);
		repeat (12) @(posedge hclk);
		rchk("status early", OFS_STATUS, 32'h0000_0000);
		repeat (25) @(posedge hclk);
		rchk("status delayed", OFS_STATUS, 32'h0000_0001);
		chk("irq masked", 32'h0000_0000, {31'h0, irq});
		sensor.drive(0, 1'b0);
		xfer(1'b1, OFS_DLY_A, 32'h0000_0000);
		xfer(1'b1, OFS_MASK, 32'h0000_0FFF);
		repeat (3) @(posedge hclk);
		chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
		xfer(1'b1, OFS_STATUS, 32'h0000_0FFF);
		rchk("status cleared", OFS_STATUS, 32'h0000_0000);
		chk("irq cleared", 32'h0000_0000, {31'h0, irq});
		// every input, its own vector
		for (int i = 0; i < NUM_IRQ; i++) begin
			exp_evt = (i % 2 == 0) ? (32'h1 << i) : (32'h1 << (FALL_LSB + i));
			sensor.drive(i, 1'b1);
			sensor.drive(i, 1'b0);
			repeat (4) @(posedge hclk);
			rchk("status vector", OFS_STATUS, exp_evt);
			chk("irq raised", 32'h0000_0001, {31'h0, irq});
			xfer(1'b1, OFS_STATUS, 32'h0000_0FFF);
		end
		rchk("catch off", OFS_CATCH, 32'h0000_0000);
		// disabled input raises nothing
		xfer(1'b1, OFS_DIS, 32'h0000_0004);
		sensor.drive(2, 1'b1);
		sensor.drive(2, 1'b0);
		repeat (4) @(posedge hclk);
		rchk("status disabled", OFS_STATUS, 32'h0000_0000);
		chk("irq disabled", 32'h0000_0000, {31'h0, irq});
		// pulse catch on terminal 7 alone
		xfer(1'b1, OFS_CATCH_EN, 32'h0000_0080);
		sensor.drive(7, 1'b1);
		repeat (3) @(posedge hclk);
		rchk("level", OFS_LEVEL, 32'h0000_0080);
		sensor.drive(7, 1'b0);
		repeat (3) @(posedge hclk);
		rchk("catch sticky", OFS_CATCH, 32'h0000_0080);
		xfer(1'b1, OFS_CATCH, 32'h0000_007F);
		rchk("catch cleared", OFS_CATCH, 32'h0000_0000);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
